// ==== core/nav_cfg_regs.svh ====
// register offsets, packet identities and layout constants
// assumes the packet framer sits in software behind the apb port
`ifndef NAV_CFG_REGS_SVH
`define NAV_CFG_REGS_SVH

// apb byte addresses
`define NCFG_ADDR_SELECT  8'h00
`define NCFG_ADDR_DATA    8'h04
`define NCFG_ADDR_COMMIT  8'h08
`define NCFG_ADDR_STATUS  8'h0c

// packet identities (184, 185, 186, 188)
`define NCFG_ID_RANGE     8'hb8
`define NCFG_ID_ALIGN     8'hb9
`define NCFG_ID_FILTER    8'hba
`define NCFG_ID_IO        8'hbc

// packet lengths (4, 73, 17, 13) and their bases in the held store
`define NCFG_LEN_RANGE    7'h04
`define NCFG_LEN_ALIGN    7'h49
`define NCFG_LEN_FILTER   7'h11
`define NCFG_LEN_IO       7'h0d
`define NCFG_BASE_RANGE   7'h00
`define NCFG_BASE_ALIGN   7'h04
`define NCFG_BASE_FILTER  7'h4d
`define NCFG_BASE_IO      7'h5e
`define NCFG_MEM_BYTES    107
`define NCFG_STG_BYTES    73
`define NCFG_STG_LAST     7'h49

// alignment layout: matrix from byte 1, offsets from byte 37
`define NCFG_OFF_MATRIX   1
`define NCFG_OFF_LEVER    37

// highest legal codes
`define NCFG_RANGE_MAX    8'h02
`define NCFG_VEHICLE_MAX  8'h0d

// full scales per range code
`define NCFG_ACC_G0       5'h02
`define NCFG_ACC_G1       5'h04
`define NCFG_ACC_G2       5'h10
`define NCFG_GYR_D0       11'h0fa
`define NCFG_GYR_D1       11'h1f4
`define NCFG_GYR_D2       11'h7d0
`define NCFG_MAG_G0       4'h2
`define NCFG_MAG_G1       4'h4
`define NCFG_MAG_G2       4'h8

`endif

// ==== core/nav_cfg_pkg.sv ====
// types carried between the decoder and the navigation core
// assumes nav_cfg_regs.svh supplies the numeric constants
package nav_cfg_pkg;

	typedef enum logic [1:0] {
		IO_INACTIVE,
		IO_OUTPUT,
		IO_INPUT,
		IO_CONTROL
	} io_class_type;

	typedef struct packed {
		logic [1:0]  accel_code;
		logic [1:0]  gyro_code;
		logic [1:0]  mag_code;
		logic [4:0]  accel_g;
		logic [10:0] gyro_dps;
		logic [3:0]  mag_gauss;
	} sensor_cfg_type;

	typedef struct packed {
		logic [3:0] vehicle;
		logic       gnss_en;
		logic       atmos_alt_en;
		logic       vel_heading_en;
		logic       reverse_det_en;
		logic       motion_en;
	} filter_cfg_type;

	typedef struct packed {
		logic [7:0]   first_code;
		io_class_type first_class;
		logic [7:0]   second_code;
		logic [7:0]   aux_tx_code;
		logic [7:0]   aux_rx_code;
	} io_cfg_type;

endpackage : nav_cfg_pkg

// ==== core/cfg_code_check.sv ====
// field code checker for a staged configuration packet
// assumes bytes 1..3 of the staged packet on its inputs
`include "nav_cfg_regs.svh"

module cfg_code_check
(
	input  wire logic [2:0]              slot,       // 0 range,1 align,2 filter,3 io
	input  wire logic [7:0]              byte1,      // staged byte 1
	input  wire logic [7:0]              byte2,      // staged byte 2
	input  wire logic [7:0]              byte3,      // staged byte 3
	output logic [2:0]                   field_ok,   // bytes 1..3 acceptable
	output nav_cfg_pkg::io_class_type    first_class // class of byte 1 as io code
);

	function automatic nav_cfg_pkg::io_class_type io_class_of(
		input logic [7:0] c);
		case (c)
			8'h00: io_class_of = nav_cfg_pkg::IO_INACTIVE;
			8'h01, 8'h02, 8'h07, 8'h0c, 8'h27, 8'h28, 8'h29, 8'h34, 8'h38:
				io_class_of = nav_cfg_pkg::IO_OUTPUT; // RQ9
			8'h03, 8'h04, 8'h05, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
			8'h1f, 8'h20, 8'h21, 8'h22, 8'h2b, 8'h2c, 8'h37:
				io_class_of = nav_cfg_pkg::IO_INPUT; // RQ10
			8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h26, 8'h2a, 8'h2d,
			8'h2e, 8'h35, 8'h36:
				io_class_of = nav_cfg_pkg::IO_CONTROL; // RQ11
			default: io_class_of = nav_cfg_pkg::IO_INACTIVE;
		endcase
	endfunction : io_class_of

	always_comb
	begin
		first_class = io_class_of(byte1);
		field_ok    = 3'b111;
		if (slot == 3'd0)
		begin
			field_ok[0] = byte1 <= `NCFG_RANGE_MAX; // RQ1
			field_ok[1] = byte2 <= `NCFG_RANGE_MAX; // RQ1
			field_ok[2] = byte3 <= `NCFG_RANGE_MAX; // RQ1
		end
		else if (slot == 3'd2)
			field_ok[0] = byte1 <= `NCFG_VEHICLE_MAX; // RQ6
		else if (slot == 3'd3)
			// unlisted codes also fall to inactive, so zero is the only
			// code that may legally map there
			field_ok[0] = (byte1 == 8'h00) ||
				(io_class_of(byte1) != nav_cfg_pkg::IO_INACTIVE); // RQ12
	end

endmodule : cfg_code_check

// ==== core/nav_config_packet_decoder.sv ====
// configuration packet decoder: stages, checks and holds four packets
// assumes an apb master that frames packets and writes them byte-wise
`include "nav_cfg_regs.svh"

// Summary of operation
// RQ1 - range codes 0..2 select full scales
// RQ2 - alignment packet 185, 73 bytes, fixed layout
// RQ3 - nine matrix words held as rotation matrix
// RQ4 - host builds matrix from heading pitch roll
// RQ5 - filter packet 186, 17 bytes, fixed layout
// RQ6 - vehicle type codes 0..13 accepted
// RQ7 - host zeroes every reserved byte
// RQ8 - io packet 188, 13 bytes, fixed layout
// RQ9 - first io line output codes decoded
// RQ10 - first io line input codes decoded
// RQ11 - first io line control codes decoded
// RQ12 - unlisted code keeps the previous field value
// RQ13 - persistence one stores to non-volatile memory
// RQ14 - every packet writable and readable back
// RQ15 - range packet 184, 4 bytes, fixed layout
module nav_config_packet_decoder
(
	input  wire logic                     pclk,             // apb clock
	input  wire logic                     presetn,          // async reset
	input  wire logic                     psel,             // apb select
	input  wire logic                     penable,          // apb enable
	input  wire logic                     pwrite,           // apb direction
	input  wire logic [7:0]               paddr,            // apb address
	input  wire logic [31:0]              pwdata,           // apb write data
	output logic [31:0]                   prdata,           // apb read data
	output logic                          pready,           // apb ready
	output logic                          pslverr,          // apb error
	output nav_cfg_pkg::sensor_cfg_type   sensor_cfg,       // sensor ranges
	output nav_cfg_pkg::filter_cfg_type   filter_cfg,       // filter options
	output nav_cfg_pkg::io_cfg_type       io_cfg,           // io functions
	output logic [8:0][31:0]              alignment_matrix, // row-major
	output logic [8:0][31:0]              lever_offsets,    // ant,odo,ext xyz
	output logic [3:0]                    nvm_store         // store pulse
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0]  mem_r [0:`NCFG_MEM_BYTES-1];
	logic [7:0]  mem_nxt [0:`NCFG_MEM_BYTES-1];
	logic [7:0]  stg_r [0:`NCFG_STG_BYTES-1];
	logic [7:0]  stg_nxt [0:`NCFG_STG_BYTES-1];
	logic [7:0]  sel_id_r, sel_id_nxt;
	logic [6:0]  idx_r, idx_nxt;
	logic [7:0]  status_r, status_nxt;
	logic [3:0]  nvm_r, nvm_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	nav_cfg_pkg::sensor_cfg_type sensor_r, sensor_nxt;
	nav_cfg_pkg::filter_cfg_type filter_r, filter_nxt;
	nav_cfg_pkg::io_class_type   class_r, class_nxt;
	nav_cfg_pkg::io_class_type   chk_class;
	logic [2:0]  field_ok;
	logic [2:0]  cslot;
	logic        setup, acc, commit, len_ok;
	logic [6:0]  cbase, clen;

	function automatic logic [2:0] slot_of(input logic [7:0] id);
		if (id == `NCFG_ID_RANGE)
			slot_of = 3'd0; // RQ15
		else if (id == `NCFG_ID_ALIGN)
			slot_of = 3'd1; // RQ2
		else if (id == `NCFG_ID_FILTER)
			slot_of = 3'd2; // RQ5
		else if (id == `NCFG_ID_IO)
			slot_of = 3'd3; // RQ8
		else
			slot_of = 3'd4;
	endfunction : slot_of

	function automatic logic [6:0] base_of(input logic [2:0] s);
		case (s)
			3'd0:    base_of = `NCFG_BASE_RANGE;
			3'd1:    base_of = `NCFG_BASE_ALIGN;
			3'd2:    base_of = `NCFG_BASE_FILTER;
			default: base_of = `NCFG_BASE_IO;
		endcase
	endfunction : base_of

	function automatic logic [6:0] len_of(input logic [2:0] s);
		case (s)
			3'd0:    len_of = `NCFG_LEN_RANGE;
			3'd1:    len_of = `NCFG_LEN_ALIGN;
			3'd2:    len_of = `NCFG_LEN_FILTER;
			3'd3:    len_of = `NCFG_LEN_IO;
			default: len_of = 7'h00;
		endcase
	endfunction : len_of

	assign setup  = psel && !penable;
	assign acc    = psel && penable && pready_r;
	assign commit = acc && pwrite && (paddr == `NCFG_ADDR_COMMIT);
	assign cslot  = slot_of(sel_id_r);
	assign cbase  = base_of(cslot);
	assign clen   = len_of(cslot);
	assign len_ok = (cslot != 3'd4) && (idx_r == clen);

	cfg_code_check u_check
	(
		.slot        (cslot),
		.byte1       (stg_r[1]),
		.byte2       (stg_r[2]),
		.byte3       (stg_r[3]),
		.field_ok    (field_ok),
		.first_class (chk_class)
	);

	////////////////////////////////////////////////////////////////////////
	// apb slave: answer one cycle after setup, zero wait states
	always_comb
	begin
		pready_nxt  = setup;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h0000_0000;
		if (setup && !pwrite)
		begin
			if (paddr == `NCFG_ADDR_SELECT)
				prdata_nxt = {17'h0_0000, idx_r, sel_id_r};
			else if (paddr == `NCFG_ADDR_DATA)
			begin
				if (cslot != 3'd4 && idx_r < clen)
					prdata_nxt = {24'h00_0000, mem_r[7'(cbase + idx_r)]}; // RQ14
			end
			else if (paddr == `NCFG_ADDR_STATUS)
				prdata_nxt = {24'h00_0000, status_r};
			else if (paddr != `NCFG_ADDR_COMMIT)
				pslverr_nxt = 1'b1;
		end
		else if (setup && paddr != `NCFG_ADDR_SELECT &&
			paddr != `NCFG_ADDR_DATA && paddr != `NCFG_ADDR_COMMIT)
			pslverr_nxt = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// staging, index and commit into the held store
	always_comb
	begin
		int k;
		k = 0;
		sel_id_nxt = sel_id_r;
		idx_nxt    = idx_r;
		status_nxt = status_r;
		nvm_nxt    = 4'h0;
		class_nxt  = class_r;
		for (int i = 0; i < `NCFG_STG_BYTES; i++)
			stg_nxt[i] = stg_r[i];
		for (int j = 0; j < `NCFG_MEM_BYTES; j++)
		begin
			mem_nxt[j] = mem_r[j];
			k = j - int'(cbase);
			if (commit && len_ok && k >= 0 && k < int'(clen))
			begin
				// a rejected code leaves only its own field untouched
				if (k < 1 || k > 3 || field_ok[k-1])
					mem_nxt[j] = stg_r[k]; // RQ12
			end
		end
		if (acc && pwrite && paddr == `NCFG_ADDR_SELECT)
		begin
			sel_id_nxt = pwdata[7:0];
			idx_nxt    = 7'h00;
		end
		else if (acc && pwrite && paddr == `NCFG_ADDR_DATA)
		begin
			// bytes beyond the longest packet are dropped, but one extra
			// is still counted so an over-long packet fails on length
			if (idx_r < `NCFG_STG_LAST)
				stg_nxt[idx_r] = pwdata[7:0];
			if (idx_r <= `NCFG_STG_LAST)
				idx_nxt = idx_r + 7'h01;
		end
		else if (acc && paddr == `NCFG_ADDR_DATA)
		begin
			if (cslot != 3'd4 && idx_r < clen)
				idx_nxt = idx_r + 7'h01; // RQ14
		end
		else if (commit)
		begin
			idx_nxt       = 7'h00;
			status_nxt    = 8'h00;
			status_nxt[0] = len_ok;
			status_nxt[1] = (cslot != 3'd4) && !len_ok; // RQ2
			status_nxt[2] = cslot == 3'd4;
			status_nxt[3] = len_ok && (field_ok != 3'b111);
			status_nxt[6:4] = len_ok ? ~field_ok : 3'b000;
			if (len_ok && stg_r[0] == 8'h01)
				nvm_nxt[cslot[1:0]] = 1'b1; // RQ13
			if (len_ok && cslot == 3'd3 && field_ok[0])
				class_nxt = chk_class; // RQ9 RQ10 RQ11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoded views of the held store
	function automatic logic [4:0] acc_g(input logic [1:0] c);
		acc_g = (c == 2'd0) ? `NCFG_ACC_G0 :
			(c == 2'd1) ? `NCFG_ACC_G1 : `NCFG_ACC_G2;
	endfunction : acc_g

	always_comb
	begin
		sensor_nxt.accel_code = mem_r[`NCFG_BASE_RANGE+1][1:0];
		sensor_nxt.gyro_code  = mem_r[`NCFG_BASE_RANGE+2][1:0];
		sensor_nxt.mag_code   = mem_r[`NCFG_BASE_RANGE+3][1:0];
		sensor_nxt.accel_g    = acc_g(sensor_nxt.accel_code); // RQ1
		sensor_nxt.gyro_dps   = (sensor_nxt.gyro_code == 2'd0) ?
			`NCFG_GYR_D0 : (sensor_nxt.gyro_code == 2'd1) ?
			`NCFG_GYR_D1 : `NCFG_GYR_D2; // RQ1
		sensor_nxt.mag_gauss  = (sensor_nxt.mag_code == 2'd0) ?
			`NCFG_MAG_G0 : (sensor_nxt.mag_code == 2'd1) ?
			`NCFG_MAG_G1 : `NCFG_MAG_G2; // RQ1
		filter_nxt.vehicle        = mem_r[`NCFG_BASE_FILTER+1][3:0]; // RQ6
		filter_nxt.gnss_en        = mem_r[`NCFG_BASE_FILTER+2] != 8'h00;
		filter_nxt.atmos_alt_en   = mem_r[`NCFG_BASE_FILTER+4] != 8'h00;
		filter_nxt.vel_heading_en = mem_r[`NCFG_BASE_FILTER+5] != 8'h00;
		filter_nxt.reverse_det_en = mem_r[`NCFG_BASE_FILTER+6] != 8'h00;
		filter_nxt.motion_en      = mem_r[`NCFG_BASE_FILTER+7] != 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// async reset drops every setting, volatile or not, until reloaded
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int j = 0; j < `NCFG_MEM_BYTES; j++)
				mem_r[j] <= 8'h00; // RQ13
			for (int i = 0; i < `NCFG_STG_BYTES; i++)
				stg_r[i] <= 8'h00;
			sel_id_r  <= 8'h00;
			idx_r     <= 7'h00;
			status_r  <= 8'h00;
			nvm_r     <= 4'h0;
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			sensor_r  <= '{2'd0, 2'd0, 2'd0, `NCFG_ACC_G0, `NCFG_GYR_D0,
				`NCFG_MAG_G0};
			filter_r  <= '0;
			class_r   <= nav_cfg_pkg::IO_INACTIVE;
		end
		else
		begin
			mem_r     <= mem_nxt;
			stg_r     <= stg_nxt;
			sel_id_r  <= sel_id_nxt;
			idx_r     <= idx_nxt;
			status_r  <= status_nxt;
			nvm_r     <= nvm_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			sensor_r  <= sensor_nxt;
			filter_r  <= filter_nxt;
			class_r   <= class_nxt;
		end
	end

	// matrix and offsets are fp32 words, little-endian in the packet
	for (genvar g = 0; g < 18; g++)
	begin : g_word
		localparam int B = `NCFG_BASE_ALIGN + `NCFG_OFF_MATRIX + 4 * g;
		if (g < 9)
		begin : g_mat
			assign alignment_matrix[g] = {mem_r[B+3], mem_r[B+2],
				mem_r[B+1], mem_r[B]}; // RQ3
		end
		else
		begin : g_lev
			assign lever_offsets[g-9] = {mem_r[B+3], mem_r[B+2],
				mem_r[B+1], mem_r[B]}; // RQ2
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign sensor_cfg = sensor_r;
	assign filter_cfg = filter_r;
	assign nvm_store  = nvm_r;
	assign io_cfg     = {mem_r[`NCFG_BASE_IO+1], class_r,
		mem_r[`NCFG_BASE_IO+2], mem_r[`NCFG_BASE_IO+3],
		mem_r[`NCFG_BASE_IO+4]}; // RQ8

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_scale_legal;
		sensor_cfg.accel_g inside {5'h02, 5'h04, 5'h10} &&
		sensor_cfg.mag_gauss inside {4'h2, 4'h4, 4'h8};
	endproperty
	a_scale_legal: assert property (p_scale_legal) // RQ1
		else $error("illegal full scale");

	property p_range_reject;
		commit && len_ok && cslot == 3'd0 && stg_r[1] > 8'h02
		|=> $stable(mem_r[1]) ##1 $stable(sensor_cfg.accel_code);
	endproperty
	a_range_reject: assert property (p_range_reject) // RQ12
		else $error("bad range code was taken");

	property p_vehicle_legal;
		filter_cfg.vehicle <= 4'hd;
	endproperty
	a_vehicle_legal: assert property (p_vehicle_legal) // RQ6
		else $error("vehicle type out of range");

	property p_io_class;
		io_cfg.first_code != 8'h00 |-> io_cfg.first_class !=
			nav_cfg_pkg::IO_INACTIVE;
	endproperty
	a_io_class: assert property (p_io_class) // RQ9
		else $error("io code held without class");

	property p_store;
		commit && len_ok && stg_r[0] == 8'h01 |=> nvm_store != 4'h0
			##1 nvm_store == 4'h0;
	endproperty
	a_store: assert property (p_store) // RQ13
		else $error("persistent commit not stored");

	property p_no_store;
		commit && stg_r[0] == 8'h00 |=> nvm_store == 4'h0;
	endproperty
	a_no_store: assert property (p_no_store) // RQ13
		else $error("volatile commit stored");

	property p_answer;
		setup |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer) // RQ14
		else $error("apb answer not one cycle");

	property p_len_err;
		commit && cslot == 3'd1 && idx_r != `NCFG_LEN_ALIGN
		|=> status_r[1] && !status_r[0];
	endproperty
	a_len_err: assert property (p_len_err) // RQ2
		else $error("short alignment packet taken");

	c_align: cover property (commit && len_ok && cslot == 3'd1);
	c_reject: cover property (commit && len_ok && field_ok != 3'b111);
	c_store: cover property (nvm_store[3]);

endmodule : nav_config_packet_decoder

// ==== bench/cfg_host_model.sv ====
// host side of the configuration link: an apb master that frames packets
// assumes the decoder answers on the apb port and takes bytes one by one
`include "nav_cfg_regs.svh"

module cfg_host_model
(
	input  wire logic        pclk,    // apb clock
	output logic             psel,    // select
	output logic             penable, // enable
	output logic             pwrite,  // direction
	output logic [7:0]       paddr,   // byte address
	output logic [31:0]      pwdata,  // write data
	input  wire logic [31:0] prdata,  // read data
	input  wire logic        pready,  // ready
	input  wire logic        pslverr  // error
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////
	// one transfer; released lines show the inverse so stale data never
	// looks valid to the slave
	task automatic xfer(input logic wr, input logic [7:0] addr,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~addr;
		pwdata <= ~wd;
	endtask : xfer

	// select, all bytes from the persistence byte on, then commit
	task automatic send(input logic [7:0] id, input logic [7:0] pkt [73],
		input int len);
		logic [31:0] rd;
		logic        err;
		xfer(1'b1, `NCFG_ADDR_SELECT, {24'h00_0000, id}, rd, err);
		// bytes past the longest packet go out as zero
		for (int i = 0; i < len; i++)
			xfer(1'b1, `NCFG_ADDR_DATA,
				{24'h00_0000, (i < 73) ? pkt[i] : 8'h00}, rd, err);
		xfer(1'b1, `NCFG_ADDR_COMMIT, 32'h0000_0000, rd, err);
	endtask : send

	// matrix for zero heading, pitch and roll: unity diagonal, so the
	// minus-sine-of-pitch element comes out zero
	function automatic logic [31:0] align_word(input int i);
		return (i % 4 == 0) ? 32'h3f80_0000 : 32'h0000_0000;
	endfunction : align_word

endmodule : cfg_host_model

// ==== bench/nav_config_packet_decoder_bench.sv ====
// self-checking bench for the configuration packet decoder
// assumes cfg_host_model as apb master and the design header constants
`include "nav_cfg_regs.svh"

module nav_config_packet_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                        pclk, presetn, psel, penable, pwrite;
	logic                        pready, pslverr, err;
	logic [7:0]                  paddr;
	logic [31:0]                 pwdata, prdata, rd;
	nav_cfg_pkg::sensor_cfg_type sensor_cfg;
	nav_cfg_pkg::filter_cfg_type filter_cfg;
	nav_cfg_pkg::io_cfg_type     io_cfg;
	logic [8:0][31:0]            alignment_matrix, lever_offsets;
	logic [3:0]                  nvm_store, store_seen;
	logic                        seen_clr;
	logic [7:0]                  pk [73];
	int                          n_mismatch, comparisons, last;
	logic [31:0] acc_g [3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0010};
	logic [31:0] gyr [3] = '{32'h0000_00fa, 32'h0000_01f4, 32'h0000_07d0};
	logic [31:0] mag [3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0008};
	nav_cfg_pkg::io_class_type cls [4] = '{nav_cfg_pkg::IO_INACTIVE,
		nav_cfg_pkg::IO_OUTPUT, nav_cfg_pkg::IO_INPUT, nav_cfg_pkg::IO_CONTROL};

	nav_config_packet_decoder u_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sensor_cfg(sensor_cfg),
		.filter_cfg(filter_cfg), .io_cfg(io_cfg),
		.alignment_matrix(alignment_matrix), .lever_offsets(lever_offsets),
		.nvm_store(nvm_store)
	);

	cfg_host_model u_host
	(
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr)
	);

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// store pulses last one cycle, so collect them between checks
	always @(posedge pclk)
		if (!presetn || seen_clr)
			store_seen <= 4'h0;
		else
			store_seen <= store_seen | nvm_store;

	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	// fields settle one cycle after the commit edge
	task automatic put(input logic [7:0] id, input int len);
		u_host.send(id, pk, len);
		repeat (2) @(negedge pclk);
	endtask : put

	task automatic chk_status(input logic [31:0] mask, input logic [31:0] exp);
		u_host.xfer(1'b0, `NCFG_ADDR_STATUS, 32'h0000_0000, rd, err);
		cmp(rd & mask, exp);
	endtask : chk_status

	task automatic put_word(input int off, input logic [31:0] w);
		for (int b = 0; b < 4; b++)
			pk[off + b] = w[8 * b +: 8];
	endtask : put_word

	function automatic logic [31:0] sens(input int a, input int g, input int m);
		return 32'({2'(a), 2'(g), 2'(m), acc_g[a][4:0], gyr[g][10:0],
			mag[m][3:0]});
	endfunction : sens

	// small offsets keep the matrix words distinct, exposing any transpose
	function automatic logic [31:0] mword(input int i);
		return u_host.align_word(i) + 32'(i);
	endfunction : mword

	function automatic int io_kind(input int c);
		case (c)
			0: return 0;
			1, 2, 7, 12, 39, 40, 41, 52, 56: return 1;
			3, 4, 5, 26, 27, 28, 29, 30, 31, 32, 33, 34, 43, 44,
			55: return 2;
			14, 15, 16, 17, 18, 38, 42, 45, 46, 53, 54: return 3;
			default: return 4;
		endcase
	endfunction : io_kind

	////////////////////////////////////////////////////////////////
	initial
	begin
		#1_000_000;
		n_mismatch++;
		complete_run();
	end

	initial
	begin
		presetn = 1'b0;
		seen_clr = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		last = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		cmp(32'(sensor_cfg), sens(0, 0, 0));
		for (int c = 0; c < 3; c++)
		begin
			pk = '{default: 8'h00};
			pk[1] = 8'(c);
			pk[2] = 8'((c + 1) % 3);
			pk[3] = 8'((c + 2) % 3);
			put(`NCFG_ID_RANGE, 4);
			cmp(32'(sensor_cfg), sens(c, (c + 1) % 3, (c + 2) % 3));
		end
		pk[1] = 8'h03;
		pk[2] = 8'h02;
		pk[3] = 8'h00;
		put(`NCFG_ID_RANGE, 4);
		cmp(32'(sensor_cfg), sens(2, 2, 0));
		chk_status(32'h0000_007f, 32'h0000_0019);
		cmp(32'(store_seen), 32'h0000_0000);

		pk = '{default: 8'h00};
		pk[0] = 8'h01;
		for (int i = 0; i < 9; i++)
		begin
			put_word(`NCFG_OFF_MATRIX + 4 * i, mword(i));
			put_word(`NCFG_OFF_LEVER + 4 * i, 32'h4120_0000 + 32'(i));
		end
		put(`NCFG_ID_ALIGN, 73);
		cmp(32'(store_seen), 32'h0000_0002);
		for (int i = 0; i < 9; i++)
		begin
			cmp(alignment_matrix[i], mword(i));
			cmp(lever_offsets[i], 32'h4120_0000 + 32'(i));
		end
		u_host.xfer(1'b1, `NCFG_ADDR_SELECT, 32'h0000_00b9, rd, err);
		for (int i = 0; i < 74; i++)
		begin
			u_host.xfer(1'b0, `NCFG_ADDR_DATA, 32'h0000_0000, rd, err);
			cmp(rd, (i < 73) ? {24'h00_0000, pk[i]} : 32'h0000_0000);
		end
		pk[1] = ~pk[1];
		for (int n = 72; n < 75; n += 2)
		begin
			put(`NCFG_ID_ALIGN, n);
			chk_status(32'h0000_0007, 32'h0000_0002);
			cmp(alignment_matrix[0], mword(0));
		end

		// vehicle, gnss, atmos, velocity, reverse, motion
		pk = '{default: 8'h00};
		pk[1] = 8'h0d;
		pk[2] = 8'h01;
		pk[4] = 8'h80;
		pk[6] = 8'h02;
		put(`NCFG_ID_FILTER, 17);
		cmp(32'(filter_cfg), 32'h0000_01ba);
		pk = '{default: 8'h00};
		pk[1] = 8'h0e;
		pk[5] = 8'h01;
		pk[7] = 8'hff;
		put(`NCFG_ID_FILTER, 17);
		cmp(32'(filter_cfg), 32'h0000_01a5);
		chk_status(32'h0000_007f, 32'h0000_0019);
		u_host.send(8'hbb, pk, 4);
		chk_status(32'h0000_0007, 32'h0000_0004);

		seen_clr <= 1'b1;
		@(posedge pclk);
		seen_clr <= 1'b0;
		for (int c = 0; c < 58; c++)
		begin
			pk = '{default: 8'h00};
			pk[0] = 8'(c == 57);
			pk[1] = 8'(c);
			pk[2] = 8'(c + 100);
			pk[3] = 8'(c + 150);
			pk[4] = 8'(c + 200);
			put(`NCFG_ID_IO, 13);
			if (io_kind(c) < 4)
				last = c;
			cmp(32'(io_cfg.first_code), 32'(last));
			cmp(32'(io_cfg.first_class), 32'(cls[io_kind(last)]));
			cmp({8'h00, io_cfg.second_code, io_cfg.aux_tx_code,
				io_cfg.aux_rx_code}, {8'h00, pk[2], pk[3], pk[4]});
		end
		cmp(32'(store_seen), 32'h0000_0008);

		// mid-run reset drops every held setting
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		cmp(32'(sensor_cfg), sens(0, 0, 0));
		cmp({24'h00_0000, io_cfg.first_code}, 32'h0000_0000);
		cmp(alignment_matrix[0], 32'h0000_0000);

		u_host.xfer(1'b1, 8'h10, 32'h0000_00ff, rd, err);
		cmp(32'(err), 32'h0000_0001);
		complete_run();
	end

endmodule : nav_config_packet_decoder_bench
